// *** emt_pkg.sv ***
/*
 * Shared constants, enumerations and configuration carriers for the
 * embedded memory tile.
 * Assumes configuration is static while the tile runs.
 */
package emt_pkg;
	// product-term mode
	localparam int NUM_MC = 16;
	localparam int NUM_IN = 32;
	localparam int NUM_CLK = 2;
	localparam int MAX_PT = 32;
	localparam int MAX_SETS = 15;
	// memory shapes
	localparam int ADDR_W = 11;
	localparam int RAM_WORDS = 128;
	localparam int RAM_W = 16;
	localparam int ROW_W = 7;
	localparam int COL_W = 4;
	localparam int PAGE_W = 2;
	localparam logic [3:0] LOG2_MAX_W = 4'h4;
	// content-addressable mode
	localparam int CAM_WORDS = 32;
	localparam int CAM_W = 32;
	localparam int CAM_AW = 5;
	// clear select codes
	localparam logic [1:0] CLR_NONE = 2'h0;
	localparam logic [1:0] CLR_A = 2'h1;
	localparam logic [1:0] CLR_B = 2'h2;
	// reset value of every register bit
	localparam logic RST_BIT = 1'h0;

	typedef enum logic [2:0] {REG_D, REG_T, REG_JK, REG_SR, REG_BYP} reg_kind_e;
	typedef enum logic [2:0] {
		MODE_PTERM, MODE_RW, MODE_IO, MODE_SP, MODE_CAM
	} mem_mode_e;
	typedef enum logic [2:0] {
		SH_128X16, SH_256X8, SH_512X4, SH_1024X2, SH_2048X1
	} shape_e;

	typedef struct packed {
		reg_kind_e kind;
		logic clk_sel;
		logic [1:0] clr_sel;
		logic lend;
		logic take;
		logic [NUM_IN-1:0] mask0;
		logic [NUM_IN-1:0] pol0;
		logic [NUM_IN-1:0] mask1;
		logic [NUM_IN-1:0] pol1;
	} mc_cfg_s;

	typedef struct packed {
		mem_mode_e mode;
		shape_e shape;
		logic [NUM_CLK-1:0] edge_fall;
		logic [NUM_CLK-1:0] clr_inv;
		logic out_reg_en;
		logic deep_en;
		logic [PAGE_W-1:0] page_id;
	} tile_cfg_s;
endpackage

// *** tile_ram.sv ***
/*
 * Bit-maskable synchronous RAM array of the memory tile.
 * Assumes write and read strobes are single-cycle pulses on one clock.
 */
`timescale 1ns/100ps
module tile_ram #(
	parameter int WORDS = 128,
	parameter int WIDTH = 16,
	parameter int AW = $clog2(WORDS)
) (
	// system
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// write port
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [WIDTH-1:0] i_wdata,
	input wire logic [WIDTH-1:0] i_wmask,
	// read port
	input wire logic i_re,
	input wire logic [AW-1:0] i_raddr,
	output logic [WIDTH-1:0] o_rdata
);
	typedef struct packed {
		logic [WORDS-1:0][WIDTH-1:0] words;
		logic [WIDTH-1:0] q;
	} ram_state_s;

	ram_state_s st_r;
	ram_state_s st_nxt;

	// read sees the old word on a same-address collision
	always_comb begin
		st_nxt = st_r;
		if (i_we) begin
			st_nxt.words[i_waddr] = (st_r.words[i_waddr] & ~i_wmask) |
				(i_wdata & i_wmask);
		end
		if (i_re) begin
			st_nxt.q = st_r.words[i_raddr];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_rdata = st_r.q;
endmodule

// *** embedded_memory_tile.sv ***
/*
 * Embedded memory tile: product-term macrocells, shaped synchronous RAM
 * with paging, and a 32-word content-addressable store.
 * Assumes fabric data and enables are on i_sys_clk; tile clock lines and
 * clear sources are foreign and are synchronised here.
 */
// Functional notes
// R1: each macrocell register acts as D, T, JK, SR or is bypassed
// R2: each macrocell picks one of two tile clock lines
// R3: each clock line has its own enable, gating every macrocell on it
// R4: rising and falling edges of one source use both clock lines
// R5: two tile clears; each macrocell picks one or none
// R6: each tile clear may be inverted
// R7: macrocell OR takes up to 32 terms: two own, thirty borrowed
// R8: borrowed terms come in pairs, at most fifteen pairs chained
// R9: memory inputs are registered; output register is optional
// R10: tile makes its own write strobe from the clock edge
// R11: shapes 128x16, 256x8, 512x4, 1024x2, 2048x1
// R12: deep memory drives shared column line only for owned page
// R13: column line never driven by two tiles, never left floating
// R14: read/write mode: write regs on one clock, read regs on other
// R15: read/write mode: enable and clear act per side independently
// R16: input/output mode: inputs on one clock, read data on other
// R17: every memory register clearable by routing, global or chip reset
// R18: dual port allows read and write in one period
// R19: single-port mode shares one address, no simultaneous access
// R20: true bidirectional dual port uses two or four tiles together
// R21: CAM compares key to all words and returns matching address
// R22: CAM match flag high when key matches a stored word
// R23: product-term mode has sixteen macrocells, two terms each
// R24: CAM holds thirty-two words of thirty-two bits
// R25: no match keeps flag low; address is invalid
`timescale 1ns/100ps
module embedded_memory_tile (
	// system
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// tile clock lines, enables and clear sources
	input wire logic [emt_pkg::NUM_CLK-1:0] i_tclk,
	input wire logic [emt_pkg::NUM_CLK-1:0] i_tce,
	input wire logic [1:0] i_aclr_src,
	input wire logic i_dev_clr_n,
	// configuration
	input wire emt_pkg::tile_cfg_s i_tile_cfg,
	input wire emt_pkg::mc_cfg_s [emt_pkg::NUM_MC-1:0] i_mc_cfg,
	// product terms
	input wire logic [emt_pkg::NUM_IN-1:0] i_pt_in,
	output logic [emt_pkg::NUM_MC-1:0] o_mc_out,
	// memory
	input wire logic i_we,
	input wire logic i_re,
	input wire logic [emt_pkg::ADDR_W-1:0] i_waddr,
	input wire logic [emt_pkg::ADDR_W-1:0] i_raddr,
	input wire logic [emt_pkg::PAGE_W-1:0] i_rpage,
	input wire logic [emt_pkg::RAM_W-1:0] i_wdata,
	output logic [emt_pkg::RAM_W-1:0] o_rdata,
	output logic [emt_pkg::RAM_W-1:0] o_col_q,
	output logic o_col_oe,
	// content-addressable
	input wire logic [emt_pkg::CAM_W-1:0] i_cam_key,
	output logic o_cam_match,
	output logic [emt_pkg::CAM_AW-1:0] o_cam_addr
);
	typedef struct packed {
		logic [1:0] tclk_s1;
		logic [1:0] tclk_s2;
		logic [1:0] tclk_prev;
		logic [1:0] clr_s1;
		logic [1:0] clr_s2;
		logic rst_s1;
		logic rst_s2;
		logic [emt_pkg::NUM_MC-1:0] mc_q;
		logic [emt_pkg::NUM_MC-1:0] mc_out;
		logic [emt_pkg::ADDR_W-1:0] wa;
		logic [emt_pkg::RAM_W-1:0] wd;
		logic wstrb;
		logic [emt_pkg::ADDR_W-1:0] ra;
		logic [emt_pkg::PAGE_W-1:0] rpage;
		logic rstrb;
		logic [emt_pkg::COL_W-1:0] rcol;
		logic rvalid;
		logic [emt_pkg::RAM_W-1:0] rq;
		logic [emt_pkg::RAM_W-1:0] col_q;
		logic col_oe;
		logic [emt_pkg::CAM_WORDS-1:0][emt_pkg::CAM_W-1:0] cam;
		logic cam_match;
		logic [emt_pkg::CAM_AW-1:0] cam_addr;
	} tile_state_s;

	tile_state_s st_r;
	tile_state_s st_nxt;

	function automatic logic pterm(input logic [31:0] x, input logic [31:0] m,
		input logic [31:0] p);
		pterm = &(~m | (x ^ p));
	endfunction

	function automatic logic [15:0] lane_mask(input emt_pkg::shape_e sh);
		case (sh)
			emt_pkg::SH_128X16: lane_mask = 16'hFFFF;
			emt_pkg::SH_256X8: lane_mask = 16'h00FF;
			emt_pkg::SH_512X4: lane_mask = 16'h000F;
			emt_pkg::SH_1024X2: lane_mask = 16'h0003;
			default: lane_mask = 16'h0001;
		endcase
	endfunction

	// word address scaled to a bit position in the 2048-bit array
	function automatic logic [10:0] bit_pos(input logic [10:0] a,
		input emt_pkg::shape_e sh);
		logic [3:0] lw;
		lw = emt_pkg::LOG2_MAX_W - 4'(sh);
		bit_pos = a << lw;
	endfunction

	// lowest index wins when several words match
	function automatic logic [4:0] first_hit(input logic [31:0] h);
		first_hit = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (h[i]) begin
				first_hit = 5'(i);
			end
		end
	endfunction

	emt_pkg::mem_mode_e mode;
	logic [1:0] tick;
	logic [1:0] clr;
	logic dev_clr;
	logic rl;
	logic ol;
	logic cw;
	logic cr;
	logic co;
	logic [emt_pkg::NUM_MC-1:0] sum;
	logic [emt_pkg::NUM_MC-1:0] pt1;
	logic [emt_pkg::NUM_MC-1:0] mc_clr;
	logic [emt_pkg::CAM_WORDS-1:0] hits;
	logic [10:0] wpos;
	logic [10:0] rpos;
	logic [emt_pkg::RAM_W-1:0] ram_q;
	logic [emt_pkg::RAM_W-1:0] rsel;

	assign mode = i_tile_cfg.mode;
	assign dev_clr = ~st_r.rst_s2; // R17
	// edge per line chosen by config, gated by that line's enable
	assign tick = (i_tile_cfg.edge_fall & st_r.tclk_prev & ~st_r.tclk_s2 |
		~i_tile_cfg.edge_fall & ~st_r.tclk_prev & st_r.tclk_s2) & i_tce; // R3 R4
	assign clr = st_r.clr_s2 ^ i_tile_cfg.clr_inv; // R6
	// clock lines: write side on line 0 always
	assign rl = (mode == emt_pkg::MODE_RW); // R14
	assign ol = (mode == emt_pkg::MODE_RW) | (mode == emt_pkg::MODE_IO); // R16
	assign cw = clr[0] | dev_clr; // R15 R17
	assign cr = (rl ? clr[1] : clr[0]) | dev_clr; // R15
	assign co = ((mode == emt_pkg::MODE_SP) ? clr[0] : clr[1]) | dev_clr;
	assign wpos = bit_pos(st_r.wa, i_tile_cfg.shape); // R11
	assign rpos = bit_pos(st_r.ra, i_tile_cfg.shape); // R11
	assign rsel = (ram_q >> st_r.rcol) & lane_mask(i_tile_cfg.shape); // R11

	// product-term network with expander chain
	always_comb begin
		logic [emt_pkg::NUM_MC-1:0] exp_c;
		logic own;
		logic chain;
		own = 1'b0;
		chain = 1'b0;
		exp_c = '0;
		sum = '0;
		pt1 = '0;
		mc_clr = '0;
		for (int i = 0; i < emt_pkg::NUM_MC; i++) begin
			own = pterm(i_pt_in, i_mc_cfg[i].mask0, i_mc_cfg[i].pol0) |
				pterm(i_pt_in, i_mc_cfg[i].mask1, i_mc_cfg[i].pol1); // R23
			pt1[i] = pterm(i_pt_in, i_mc_cfg[i].mask1, i_mc_cfg[i].pol1);
			chain = (i > 0) && i_mc_cfg[i].take && exp_c[(i + 15) % 16];
			// a lender passes its pair plus the chain on; at most 15 links
			exp_c[i] = i_mc_cfg[i].lend & (own | chain); // R7 R8
			sum[i] = (~i_mc_cfg[i].lend & own) | (~i_mc_cfg[i].lend & chain);
			mc_clr[i] = dev_clr |
				(i_mc_cfg[i].clr_sel == emt_pkg::CLR_A & clr[0]) |
				(i_mc_cfg[i].clr_sel == emt_pkg::CLR_B & clr[1]); // R5
		end
	end

	always_comb begin
		hits = '0;
		for (int w = 0; w < emt_pkg::CAM_WORDS; w++) begin
			hits[w] = (st_r.cam[w] == i_cam_key); // R21 R24
		end
	end

	always_comb begin
		logic q;
		q = 1'b0;
		st_nxt = st_r;
		st_nxt.tclk_s1 = i_tclk;
		st_nxt.tclk_s2 = st_r.tclk_s1;
		st_nxt.tclk_prev = st_r.tclk_s2;
		st_nxt.clr_s1 = i_aclr_src;
		st_nxt.clr_s2 = st_r.clr_s1;
		st_nxt.rst_s1 = i_dev_clr_n;
		st_nxt.rst_s2 = st_r.rst_s1;
		st_nxt.wstrb = 1'b0;
		st_nxt.rstrb = 1'b0;
		st_nxt.rvalid = st_r.rstrb;
		// macrocells
		for (int i = 0; i < emt_pkg::NUM_MC; i++) begin
			q = st_r.mc_q[i];
			if (mode != emt_pkg::MODE_PTERM || mc_clr[i]) begin
				q = emt_pkg::RST_BIT; // R5
			end else if (tick[i_mc_cfg[i].clk_sel]) begin // R2 R3
				case (i_mc_cfg[i].kind) // R1
					emt_pkg::REG_D: q = sum[i];
					emt_pkg::REG_T: q = st_r.mc_q[i] ^ sum[i];
					emt_pkg::REG_JK: q = (sum[i] & ~st_r.mc_q[i]) |
						(~pt1[i] & st_r.mc_q[i]);
					emt_pkg::REG_SR: q = sum[i] | (~pt1[i] & st_r.mc_q[i]);
					default: q = st_r.mc_q[i];
				endcase
			end
			st_nxt.mc_q[i] = q;
			st_nxt.mc_out[i] = (i_mc_cfg[i].kind == emt_pkg::REG_BYP) ?
				sum[i] : q; // R1
		end
		// write-side input registers; strobe is made here, not by fabric
		if (cw) begin
			st_nxt.wa = '0;
			st_nxt.wd = '0;
		end else if (tick[0] && mode != emt_pkg::MODE_PTERM &&
			mode != emt_pkg::MODE_CAM) begin // R9 R14
			st_nxt.wa = i_waddr;
			st_nxt.wd = i_wdata;
			st_nxt.wstrb = i_we; // R10 R18
		end
		// read-side input registers
		if (cr) begin
			st_nxt.ra = '0;
			st_nxt.rpage = '0;
		end else if (tick[rl] && (mode == emt_pkg::MODE_RW ||
			mode == emt_pkg::MODE_IO)) begin // R14 R16
			st_nxt.ra = i_raddr;
			st_nxt.rpage = i_rpage;
			st_nxt.rstrb = i_re;
		end else if (tick[0] && mode == emt_pkg::MODE_SP) begin
			st_nxt.ra = i_waddr; // R19
			st_nxt.rpage = i_rpage;
			st_nxt.rstrb = i_re & ~i_we; // R19
		end
		if (st_nxt.rstrb) begin
			st_nxt.rcol = 4'(bit_pos(st_nxt.ra, i_tile_cfg.shape));
		end
		// optional output register, else loaded when read data lands
		if (co) begin
			st_nxt.rq = '0; // R17
		end else if (i_tile_cfg.out_reg_en ? tick[ol] : st_r.rvalid) begin
			st_nxt.rq = rsel; // R9 R16
		end
		// only the tile owning the page drives the column line
		st_nxt.col_oe = i_tile_cfg.deep_en &&
			(st_r.rpage == i_tile_cfg.page_id); // R12 R13
		st_nxt.col_q = st_nxt.col_oe ? st_nxt.rq : '0; // R12
		// content-addressable store
		if (mode == emt_pkg::MODE_CAM && tick[0] && i_we && !cw) begin
			st_nxt.cam[i_waddr[emt_pkg::CAM_AW-1:0]] = i_cam_key;
		end
		if (cw || mode != emt_pkg::MODE_CAM) begin
			st_nxt.cam_match = 1'b0;
			st_nxt.cam_addr = '0;
		end else begin
			st_nxt.cam_match = |hits; // R22 R25
			st_nxt.cam_addr = first_hit(hits); // R21 R25
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	// one write and one read port per tile; bidirectional pairs use peers
	tile_ram #(
		.WORDS(emt_pkg::RAM_WORDS),
		.WIDTH(emt_pkg::RAM_W)
	) u_ram (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_we(st_r.wstrb), // R10 R18 R20
		.i_waddr(wpos[10:4]),
		.i_wdata(st_r.wd << wpos[3:0]),
		.i_wmask(lane_mask(i_tile_cfg.shape) << wpos[3:0]),
		.i_re(st_r.rstrb),
		.i_raddr(rpos[10:4]),
		.o_rdata(ram_q)
	);

	assign o_mc_out = st_r.mc_out;
	assign o_rdata = st_r.rq;
	assign o_col_q = st_r.col_q;
	assign o_col_oe = st_r.col_oe;
	assign o_cam_match = st_r.cam_match;
	assign o_cam_addr = st_r.cam_addr;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_cam_nomatch_addr: assert property ( // R25
		!st_r.cam_match |-> st_r.cam_addr == '0)
		else $error("cam address not zero without match");
	a_cam_match_set: assert property ( // R22
		i_ce && mode == emt_pkg::MODE_CAM && !cw && |hits |=> st_r.cam_match)
		else $error("cam match flag missed a hit");
	a_cam_addr_hit: assert property ( // R21
		i_ce && mode == emt_pkg::MODE_CAM && !cw && |hits
		|=> st_r.cam_addr == $past(first_hit(hits)))
		else $error("cam address not the matching word");
	a_col_page_own: assert property ( // R13
		i_ce ##1 st_r.col_oe |-> $past(i_tile_cfg.deep_en) &&
		$past(st_r.rpage) == $past(i_tile_cfg.page_id))
		else $error("column line driven for a foreign page");
	a_wr_strobe_pulse: assert property ( // R10
		i_ce && tick[0] && i_we && !cw && (mode == emt_pkg::MODE_RW ||
		mode == emt_pkg::MODE_SP) |=> st_r.wstrb ##1
		(!st_r.wstrb || !$past(i_ce)))
		else $error("internal write strobe not a single pulse");
	a_mc_clear_wins: assert property ( // R5
		i_ce && mc_clr[0] |=> st_r.mc_q[0] == 1'b0)
		else $error("macrocell clear did not act");
	a_mc_clk_gate: assert property ( // R3
		i_ce && mode == emt_pkg::MODE_PTERM && !mc_clr[0] &&
		!tick[i_mc_cfg[0].clk_sel] |=> $stable(st_r.mc_q[0]))
		else $error("macrocell changed without its clock enable");
	a_mc_d_load: assert property ( // R1
		i_ce && mode == emt_pkg::MODE_PTERM && !mc_clr[0] &&
		tick[i_mc_cfg[0].clk_sel] && i_mc_cfg[0].kind == emt_pkg::REG_D
		|=> st_r.mc_q[0] == $past(sum[0]))
		else $error("d-type macrocell did not load its sum");
	// only a fresh load is checked: a shape change leaves old data standing
	a_rdata_width: assert property ( // R11
		i_ce && !co && st_r.rvalid && !i_tile_cfg.out_reg_en
		|=> (st_r.rq & ~$past(lane_mask(i_tile_cfg.shape))) == '0)
		else $error("read data wider than the shape");
endmodule

// *** fabric_model.sv ***
/*
 * Fabric-side model of the logic that drives the tile clock lines.
 * Assumes the caller runs on i_sys_clk; the lines rest low between pulses.
 */
`timescale 1ns/100ps
module fabric_model (
	// system
	input wire logic i_sys_clk,
	// tile clock lines
	output logic [1:0] o_tclk
);
	initial o_tclk = 2'h0;

	// long high and low phases so both edges clear the 2-flop sync
	task automatic pulse(input int k);
		@(posedge i_sys_clk);
		o_tclk[k] <= 1'h1;
		repeat (5) @(posedge i_sys_clk);
		o_tclk[k] <= 1'h0;
		repeat (6) @(posedge i_sys_clk);
	endtask
endmodule

// *** embedded_memory_tile_test.sv ***
/*
 * Self-checking bench of the embedded memory tile with a reference model.
 * Assumes tile clock lines come only from fabric_model pulses.
 */
`timescale 1ns/100ps
module embedded_memory_tile_test;
	logic i_sys_clk, i_rst_n, i_ce, i_dev_clr_n, i_we, i_re, col_oe, cam_m;
	logic [1:0] tclk, i_tce, i_aclr_src, i_rpage;
	emt_pkg::tile_cfg_s cfg;
	emt_pkg::mc_cfg_s [15:0] mc;
	logic [31:0] pt, key, seed, cm [32];
	logic [10:0] waddr, raddr;
	logic [15:0] wdata, rdata, col_q, mc_out, q;
	logic [15:0] mem [int];
	logic [4:0] cam_a;
	int n_mismatch, compares;

	fabric_model u_fab (.i_sys_clk(i_sys_clk), .o_tclk(tclk));
	embedded_memory_tile DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_ce(i_ce), .i_tclk(tclk), .i_tce(i_tce), .i_aclr_src(i_aclr_src),
		.i_dev_clr_n(i_dev_clr_n), .i_tile_cfg(cfg), .i_mc_cfg(mc),
		.i_pt_in(pt), .o_mc_out(mc_out), .i_we(i_we), .i_re(i_re),
		.i_waddr(waddr), .i_raddr(raddr), .i_rpage(i_rpage),
		.i_wdata(wdata), .o_rdata(rdata), .o_col_q(col_q), .o_col_oe(col_oe),
		.i_cam_key(key), .o_cam_match(cam_m), .o_cam_addr(cam_a));

	initial begin
		i_sys_clk = 1'h0;
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// reference register step: JK and SR take pt1 as second input
	function automatic logic nq(input int kd, input logic o, s, r);
		case (kd)
			0: return s;
			1: return o ^ s;
			2: return (s & ~o) | (~r & o);
			3: return s ? 1'h1 : (r ? 1'h0 : o);
			default: return s;
		endcase
	endfunction

	task automatic chk_val(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_flag(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic final_report();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wr(input logic [10:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_we <= 1'h1;
		waddr <= a;
		wdata <= d;
		u_fab.pulse(0);
		@(posedge i_sys_clk);
		i_we <= 1'h0;
	endtask

	// single-port mode reads through the write address
	task automatic rd(input logic [10:0] a, input int k);
		@(posedge i_sys_clk);
		i_re <= 1'h1;
		raddr <= a;
		waddr <= a;
		u_fab.pulse(k);
		@(posedge i_sys_clk);
		i_re <= 1'h0;
		repeat (3) @(posedge i_sys_clk);
		#1;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		final_report();
	end

	initial begin
		automatic emt_pkg::mem_mode_e md [3] = '{emt_pkg::MODE_SP,
			emt_pkg::MODE_IO, emt_pkg::MODE_RW};
		automatic int ca [5] = '{0, 31, 5, 17, 9};
		logic [31:0] p, x, dm, wm;
		int e;
		seed = 32'h0000F636;
		{i_rst_n, i_we, i_re, i_aclr_src, i_rpage, pt, key} = '0;
		{waddr, raddr, wdata, q} = '0;
		{i_ce, i_dev_clr_n, i_tce} = 4'hF;
		cfg = '0;
		cfg.mode = emt_pkg::MODE_CAM;
		for (int i = 0; i < 16; i++) begin
			mc[i] = '0;
			mc[i].clk_sel = i[0];
			mc[i].mask0 = 32'h00000001 << i;
			mc[i].mask1 = 32'h00000001 << (i + 16);
		end
		foreach (cm[j]) cm[j] = '0;
		repeat (20) @(posedge i_sys_clk);
		i_rst_n <= 1'h1;
		repeat (5) @(posedge i_sys_clk);
		// word 9 repeats word 5's key: the lower index must answer
		for (int j = 0; j < 5; j++) begin
			x = (j == 4) ? cm[5] : rnd();
			cm[ca[j]] = x;
			key <= x;
			wr(11'(ca[j]), 16'h0000);
		end
		for (int j = 0; j < 6; j++) begin
			x = (j < 5) ? cm[ca[j]] : rnd();
			e = -1;
			for (int n = 31; n >= 0; n--) if (cm[n] == x) e = n;
			@(posedge i_sys_clk);
			key <= x;
			repeat (3) @(posedge i_sys_clk);
			#1;
			chk_flag("cam_match", e >= 0, cam_m);
			chk_val("cam_addr", (e >= 0) ? e : 0, cam_a);
		end
		foreach (md[m]) begin
			for (int s = 0; s < 5; s++) begin
				@(posedge i_sys_clk);
				cfg.mode <= md[m];
				cfg.shape <= emt_pkg::shape_e'(s);
				mem.delete();
				dm = (32'h80 << s) - 1;
				wm = (32'h1 << (16 >> s)) - 1;
				for (int j = 0; j < 3; j++) begin
					p = rnd() & dm;
					x = rnd() & wm;
					mem[p] = x[15:0];
					wr(p[10:0], x[15:0]);
				end
				foreach (mem[a]) begin
					rd(a[10:0], (md[m] == emt_pkg::MODE_RW) ? 1 : 0);
					chk_val("rdata", mem[a], rdata);
				end
			end
		end
		@(posedge i_sys_clk);
		cfg.mode <= emt_pkg::MODE_SP;
		cfg.shape <= emt_pkg::SH_128X16;
		cfg.deep_en <= 1'h1;
		cfg.page_id <= 2'h2;
		x = rnd();
		wr(11'h005, x[15:0]);
		for (int pg = 0; pg < 4; pg++) begin
			i_rpage <= 2'(pg);
			rd(11'h005, 0);
			chk_flag("col_oe", pg == 2, col_oe);
			chk_val("col_q", (pg == 2) ? x[15:0] : 16'h0000, col_q);
		end
		// chip clear empties the output register
		@(posedge i_sys_clk);
		i_dev_clr_n <= 1'h0;
		repeat (4) @(posedge i_sys_clk);
		#1;
		chk_val("rdata", 16'h0000, rdata);
		@(posedge i_sys_clk);
		i_dev_clr_n <= 1'h1;
		cfg.out_reg_en <= 1'h1;
		p = rnd();
		wr(11'h006, p[15:0]);
		// registered output lags one out-line tick behind the array
		rd(11'h006, 0);
		chk_val("rdata", x[15:0], rdata);
		u_fab.pulse(0);
		#1;
		chk_val("rdata", p[15:0], rdata);
		@(posedge i_sys_clk);
		cfg.mode <= emt_pkg::MODE_PTERM;
		cfg.edge_fall <= 2'h2;
		for (int kd = 0; kd < 5; kd++) begin
			for (int i = 0; i < 16; i++) mc[i].kind <= emt_pkg::reg_kind_e'(kd);
			for (int v = 0; v < 4; v++) begin
				p = rnd();
				@(posedge i_sys_clk);
				pt <= p;
				i_tce <= (v == 3) ? 2'h0 : 2'h3;
				u_fab.pulse(v % 2);
				#1;
				for (int i = 0; i < 16; i++) begin
					// bypass leaves the register model untouched
					if (kd != 4 && v != 3 && i % 2 == v % 2)
						q[i] = nq(kd, q[i], p[i] | p[i + 16], p[i + 16]);
				end
				wm = (kd == 4) ? p[15:0] | p[31:16] : q;
				chk_val("mc_out", wm[15:0], mc_out);
			end
		end
		for (int i = 0; i < 16; i++) begin
			mc[i].kind <= emt_pkg::REG_D;
			mc[i].clr_sel <= i[0] ? emt_pkg::CLR_B : emt_pkg::CLR_A;
		end
		@(posedge i_sys_clk);
		i_aclr_src <= 2'h1;
		i_tce <= 2'h3;
		repeat (8) @(posedge i_sys_clk);
		#1;
		chk_val("mc_out", q & 16'hAAAA, mc_out);
		// inverting both flips which clear is active
		cfg.clr_inv <= 2'h3;
		pt <= 32'hFFFFFFFF;
		repeat (8) @(posedge i_sys_clk);
		u_fab.pulse(0);
		#1;
		chk_val("mc_out", 16'h5555, mc_out);
		// cells 0 and 1 lend their pairs down the chain to cell 2
		for (int i = 0; i < 3; i++) begin
			mc[i].kind <= emt_pkg::REG_BYP;
			mc[i].lend <= (i < 2);
			mc[i].take <= (i > 0);
		end
		foreach (ca[j]) begin
			@(posedge i_sys_clk);
			pt <= 32'h00000001 << ca[j];
			repeat (2) @(posedge i_sys_clk);
			#1;
			chk_val("mc_exp", (ca[j] % 16 < 3) ? 3'h4 : 3'h0,
				mc_out[2:0]);
		end
		// clock enable low freezes the whole tile
		@(posedge i_sys_clk);
		i_ce <= 1'h0;
		pt <= 32'h00000001;
		repeat (3) @(posedge i_sys_clk);
		#1;
		chk_val("mc_exp", 3'h0, mc_out[2:0]);
		@(posedge i_sys_clk);
		i_ce <= 1'h1;
		repeat (2) @(posedge i_sys_clk);
		#1;
		chk_val("mc_exp", 3'h4, mc_out[2:0]);
		final_report();
	end
endmodule
